// *** gls_defines.vh ***
// Purpose: constants for the gpio and status lamp port
// Assumes: 25 MHz system clock
// Notes: times in ns, counts derived from them
`ifndef GLS_DEFINES_VH
`define GLS_DEFINES_VH
`define GLS_NPINS 3
`define GLS_CLK_PERIOD_NS 40
`define GLS_BLINK_TIME_NS 80000000
`define GLS_BLINK_CYCLES (`GLS_BLINK_TIME_NS / `GLS_CLK_PERIOD_NS)
`define GLS_TYPE_INPUT 2'h0
`define GLS_TYPE_PUSHPULL 2'h1
`define GLS_TYPE_OPENDRAIN 2'h2
`define GLS_SPEED_PIN 0
`define GLS_LINK_PIN 1
`define GLS_DUPLEX_PIN 2
`endif

// *** gls_gpio_lamp_port.v ***
// Purpose: three-pin gpio port shared with three open-drain status lamps
// Assumes: link status inputs come from logic on clk_sys
// Notes: pin i maps to lamp i+1 (speed, link/activity, duplex)
// Functional notes
// - Each pin is set by software as input, push-pull output or open-drain output.
// - A pin given to its lamp function drives open-drain whatever its output type.
// - The speed lamp is low at 100 Mb/s, in auto-negotiation and unplugged, high only at 10.
// - The link/activity lamp is low with a valid link and no blink in progress.
// - Activity makes the link lamp high for 80 ms, then low for at least 80 ms before another.
// - The duplex lamp is low while the link runs full duplex.
`timescale 1ns/1ps
`include "gls_defines.vh"
module gls_gpio_lamp_port #(
  parameter BLINK_CYCLES = `GLS_BLINK_CYCLES
) (
  input wire clk_sys,
  input wire nrst,
  input wire [5:0] pin_type,
  input wire [2:0] pin_out_value,
  input wire [2:0] lamp_select,
  input wire link_valid,
  input wire speed_10,
  input wire autoneg_busy,
  input wire full_duplex,
  input wire activity,
  input wire [2:0] gpio_in,
  output reg [2:0] gpio_out,
  output reg [2:0] gpio_oe,
  output reg [2:0] pin_read_value
);
  // ----------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;
  reg [2:0] in_meta;
  reg [2:0] in_sync;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_meta <= 3'h0;
      in_sync <= 3'h0;
    end else begin
      in_meta <= gpio_in;
      in_sync <= in_meta;
    end
  end
  // ----------------------------------------
  // link/activity blink machine
  // ----------------------------------------
  localparam ST_SOLID = 3'h1;
  localparam ST_OFF = 3'h2;
  localparam ST_HOLD = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  localparam [31:0] BLINK_LAST_FULL = BLINK_CYCLES - 1;
  localparam [21:0] BLINK_LAST = BLINK_LAST_FULL[21:0];
  reg [21:0] count;
  wire count_done;

  assign count_done = (count == BLINK_LAST);
  always @* begin
    next_state = state;
    case (state)
      ST_SOLID: begin
        if (link_valid && activity) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (count_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (count_done) begin
          next_state = ST_SOLID;
        end
      end
      default: begin
        next_state = ST_SOLID;
      end
    endcase
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SOLID;
    end else begin
      state <= next_state;
    end
  end

  // count restarts on every state change
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 22'h0;
    end else if (next_state != state) begin
      count <= 22'h0;
    end else begin
      count <= count + 22'h1;
    end
  end

  // ----------------------------------------
  // pin decode helpers
  // ----------------------------------------
  function drive_enable;
    input [1:0] kind;
    input value;
    input as_lamp;
    input released;
    begin
      if (as_lamp) begin
        drive_enable = !released;
      end else begin
        case (kind)
          `GLS_TYPE_INPUT: begin
            drive_enable = 1'b0;
          end
          `GLS_TYPE_PUSHPULL: begin
            drive_enable = 1'b1;
          end
          `GLS_TYPE_OPENDRAIN: begin
            drive_enable = !value;
          end
          default: begin
            drive_enable = 1'b0;
          end
        endcase
      end
    end
  endfunction

  // lamp pins only ever sink
  function drive_value;
    input [1:0] kind;
    input value;
    input as_lamp;
    begin
      if (as_lamp) begin
        drive_value = 1'b0;
      end else begin
        case (kind)
          `GLS_TYPE_PUSHPULL: begin
            drive_value = value;
          end
          `GLS_TYPE_OPENDRAIN: begin
            drive_value = 1'b0;
          end
          `GLS_TYPE_INPUT: begin
            drive_value = 1'b0;
          end
          default: begin
            drive_value = 1'b0;
          end
        endcase
      end
    end
  endfunction

  // ----------------------------------------
  // lamp levels, 1 = released
  // ----------------------------------------
  wire [2:0] lamp_released;
  wire link_blink_off;

  assign link_blink_off = (state == ST_OFF);
  assign lamp_released[`GLS_SPEED_PIN] = speed_10 && link_valid && !autoneg_busy;
  assign lamp_released[`GLS_LINK_PIN] = !link_valid || link_blink_off;
  assign lamp_released[`GLS_DUPLEX_PIN] = !(link_valid && full_duplex);

  // ----------------------------------------
  // per-pin drivers
  // ----------------------------------------
  wire [2:0] next_out;
  wire [2:0] next_oe;
  genvar g;

  generate
    for (g = 0; g < `GLS_NPINS; g = g + 1) begin : pin_slice
      assign next_out[g] = drive_value(pin_type[2*g+1:2*g], pin_out_value[g], lamp_select[g]);
      assign next_oe[g] = drive_enable(pin_type[2*g+1:2*g], pin_out_value[g], lamp_select[g],
        lamp_released[g]);
    end
  endgenerate

  // ----------------------------------------
  // registered pin outputs
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out <= 3'h0;
    end else begin
      gpio_out <= next_out;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_oe <= 3'h0;
    end else begin
      gpio_oe <= next_oe;
    end
  end

  // ----------------------------------------
  // synchronised pin read back
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_read_value <= 3'h0;
    end else begin
      pin_read_value <= in_sync;
    end
  end
endmodule

// *** gls_pin_model.sv ***
// Purpose: pin wires
// Assumes: pull-up on each pin
// Notes: ext_low drives low
`timescale 1ns/1ps
module gls_pin_model (input wire [2:0] gpio_out, gpio_oe, ext_low, output wire [2:0] gpio_in);
  assign gpio_in = ~(gpio_oe & ~gpio_out) & ~ext_low;
endmodule

// *** gls_monitor.sv ***
// Purpose: port checker
// Assumes: blink of 8 cycles
// Notes: bound in bench
`timescale 1ns/1ps
module gls_monitor #(parameter BLINK_CYCLES = 8) (
  input wire clk_sys, nrst, link_valid, speed_10, autoneg_busy, full_duplex,
  input wire [5:0] pin_type,
  input wire [2:0] lamp_select, gpio_oe, gpio_out);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  push_pull_a: assert property (pin_type[1:0] == 2'h1 && !lamp_select[0] |=> gpio_oe[0])
    else $error("push-pull pin not driven");
  lamp_open_drain_a: assert property (!(gpio_oe & gpio_out & $past(lamp_select)))
    else $error("lamp pin driven high");
  speed_lamp_a: assert property (lamp_select[0] |=>
    gpio_oe[0] != $past(link_valid & speed_10 & !autoneg_busy)) else $error("speed lamp wrong");
  blink_off_a: assert property ($fell(gpio_oe[1]) && $past(lamp_select[1]) &&
    $past(lamp_select[1], 2) && $past(link_valid) |->
    !gpio_oe[1] [*8] ##1 gpio_oe[1]) else $error("blink off length wrong");
  blink_hold_a: assert property ($rose(gpio_oe[1]) && $past(lamp_select[1]) &&
    $past(lamp_select[1], 2) && $past(link_valid) && $past(link_valid, 2) |->
    gpio_oe[1] [*8]) else $error("blink hold too short");
  duplex_lamp_a: assert property (lamp_select[2] |=>
    gpio_oe[2] == $past(link_valid & full_duplex)) else $error("duplex lamp wrong");
endmodule

// *** gls_gpio_lamp_port_tb_top.sv ***
// Purpose: random and corner bench
// Assumes: blink of 8 cycles
// Notes: seed 59
`timescale 1ns/1ps
module gls_gpio_lamp_port_tb_top;
  reg clk_sys = 0, nrst = 0, link_valid = 0, speed_10 = 0, autoneg_busy = 0, full_duplex = 0;
  reg activity = 0;
  reg [5:0] pin_type = 0;
  reg [2:0] pin_out_value = 0, lamp_select = 0, ext_low = 0;
  wire [2:0] gpio_in, gpio_out, gpio_oe, pin_read_value;
  integer fail_count = 0, checks = 0, i, lo = 0;
  reg [31:0] r;
  reg [5:0] e;
  gls_gpio_lamp_port #(.BLINK_CYCLES(8)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .pin_type(pin_type), .pin_out_value(pin_out_value),
    .lamp_select(lamp_select), .link_valid(link_valid), .speed_10(speed_10),
    .autoneg_busy(autoneg_busy), .full_duplex(full_duplex), .activity(activity),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_read_value(pin_read_value));
  gls_pin_model PM (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_low(ext_low), .gpio_in(gpio_in));
  initial forever #20 clk_sys = ~clk_sys;
  function [5:0] exp_pins(input [5:0] ty, input [2:0] v, ls, input lk, s10, an, fd);
    reg [2:0] rel, oe, out;
    integer p;
    begin
      rel = {!(lk && fd), !lk, lk && s10 && !an};
      for (p = 0; p < 3; p++) begin
        oe[p] = ls[p] ? !rel[p] : (ty[2*p +: 2] == 2'h1) || (ty[2*p +: 2] == 2'h2 && !v[p]);
        out[p] = !ls[p] && ty[2*p +: 2] == 2'h1 && v[p];
      end
      exp_pins = {oe, out};
    end
  endfunction
  task chk(input string s, input [5:0] x, g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", s, x, g);
    end
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(59));
    repeat (5) @(negedge clk_sys);
    nrst = 1;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 300; i++) begin
      r = $urandom;
      {pin_type, pin_out_value, lamp_select, ext_low} = r[14:0];
      {link_valid, speed_10, autoneg_busy, full_duplex} = i < 16 ? i[3:0] : r[18:15];
      repeat (4) @(negedge clk_sys);
      e = exp_pins(pin_type, pin_out_value, lamp_select, link_valid, speed_10, autoneg_busy,
        full_duplex);
      chk("oe_out", e, {gpio_oe, gpio_out});
      chk("read", {3'h0, ~(e[5:3] & ~e[2:0]) & ~ext_low}, {3'h0, pin_read_value});
    end
    {pin_type, lamp_select, ext_low} = 12'h005;
    repeat (5) @(negedge clk_sys);
    chk("pin", 6'h02, {gpio_oe, pin_read_value});
    $display("random done");
    {lamp_select, link_valid} = 4'hf;
    @(negedge clk_sys);
    activity = 1;
    repeat (17) @(negedge clk_sys) lo += !gpio_oe[1];
    chk("blink", 6'h08, lo[5:0]);
    repeat (10) @(negedge clk_sys);
    $display("blink done");
    finish_test;
  end
endmodule
bind gls_gpio_lamp_port gls_monitor #(.BLINK_CYCLES(8)) MON (
  .clk_sys(clk_sys), .nrst(nrst), .link_valid(link_valid), .speed_10(speed_10),
  .autoneg_busy(autoneg_busy), .full_duplex(full_duplex), .pin_type(pin_type),
  .lamp_select(lamp_select), .gpio_oe(gpio_oe), .gpio_out(gpio_out));
